// >>> inc/isb_consts.svh
// Operation
// - Match programmable 7-bit own address
// - Master NACK on sent byte sets read-done
// - Read address sets read-active; read-done clears it
// - Reading past buffer end sets read-overrun
// - Stop after addressed write sets write-done
// - Write address sets write-active; write-done clears it
// - Byte past write buffer: NACK, write-overrun
// - Combined status holds independent flag bits
// - Read-flag clear returns flags, keeps read-active
// - Write-flag clear returns flags, keeps write-active
// - Outgoing setup loads base, size, zeroes count
// - Incoming setup loads base, size, zeroes count
// - Outgoing count saturates at buffer size
// - Incoming count saturates at buffer size
// - Outgoing rewind restarts at first byte
// - Sleep: finish transaction, then NACK own address
// - Asleep own address match gives wake event
// - After wake, release held clock and serve
// - No outgoing buffer returns all-ones bytes
// - No incoming buffer: NACK writes
`ifndef ISB_CONSTS_SVH
`define ISB_CONSTS_SVH
// ==========================================================
// Register byte offsets
`define ISB_OFF_STATUS   8'h00
`define ISB_OFF_CLR_RD   8'h04
`define ISB_OFF_CLR_WR   8'h08
`define ISB_OFF_ADDR     8'h0C
`define ISB_OFF_OUT_CFG  8'h10
`define ISB_OFF_IN_CFG   8'h14
`define ISB_OFF_OUT_CNT  8'h18
`define ISB_OFF_IN_CNT   8'h1C
`define ISB_OFF_CTRL     8'h20
`define ISB_OFF_SLEEP    8'h24
`define ISB_OFF_OUT_DATA 8'h28
`define ISB_OFF_IN_DATA  8'h2C
// ==========================================================
// Status bit positions and masks
`define ISB_F_RD_DONE 0
`define ISB_F_RD_ACT  1
`define ISB_F_RD_OVR  2
`define ISB_F_WR_DONE 4
`define ISB_F_WR_ACT  5
`define ISB_F_WR_OVR  6
`define ISB_RD_BITS   8'h07
`define ISB_RD_CLR    8'h05
`define ISB_WR_BITS   8'h70
`define ISB_WR_CLR    8'h50
// ==========================================================
// Control bits, resets, codes
`define ISB_C_EN      0
`define ISB_C_RW_OUT  1
`define ISB_C_RW_IN   2
`define ISB_C_SLEEP   3
`define ISB_C_WAKE_EN 4
`define ISB_C_RESTORE 5
`define ISB_RST_ADDR  7'h08
`define ISB_RST_BYTE  8'h00
`define ISB_IDLE_BYTE 8'hFF
`define ISB_BITS_BYTE 4'h8
`define ISB_RESP_OK   2'h0
`define ISB_RESP_ERR  2'h2
`endif

// >>> inc/isb_pkg.sv
package isb_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_RACK,
    ST_TXLD, ST_TX, ST_TXACK, ST_WAKE
  } isb_state_type;

  typedef struct packed {
    isb_state_type state;
    logic [2:0]    scl_s;
    logic [2:0]    sda_s;
    logic [3:0]    bits;
    logic [7:0]    sh;
    logic          rw;
    logic          acked;
    logic          scl_oen;
    logic          sda_oen;
    logic          bus_busy;
    logic [7:0]    flags;
    logic [6:0]    own;
    logic          en;
    logic [7:0]    out_base;
    logic [7:0]    out_size;
    logic [7:0]    out_cnt;
    logic [7:0]    in_base;
    logic [7:0]    in_size;
    logic [7:0]    in_cnt;
    logic [7:0]    in_ptr;
    logic          sleep_req;
    logic          wake_en;
    logic          asleep;
    logic          wake;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic [1:0]    bresp;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    awaddr_h;
    logic [31:0]   wdata_h;
    logic [3:0]    wstrb_h;
  } isb_regs_type;
endpackage

// >>> logic/isb_slave.sv
`include "isb_consts.svh"

module isb_slave import isb_pkg::*; #(
  parameter int DEPTH = 256
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Two-wire bus pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  // Power management
  output logic             wake_pulse,
  output logic             asleep
);

  // ========================================================
  // Parameter check and storage
  if (DEPTH < 2 || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two from 2 to 256");
  end

  logic [7:0] out_mem [DEPTH];
  logic [7:0] in_mem  [DEPTH];

  isb_regs_type r;
  isb_regs_type n;

  logic       scl_rise, scl_fall, start_ev, stop_ev, matched;
  logic       wr_exec, rd_take;
  logic [7:0] set_f, clr_f;
  logic       out_we, in_we;
  logic [7:0] out_wa, in_wa, out_wd;

  // Buffer position: base plus count, wrapped to the array
  function automatic logic [7:0] buf_idx(input logic [7:0] base,
                                         input logic [7:0] cnt);
    logic [8:0] s;
    s = {1'b0, base} + {1'b0, cnt};
    return s[7:0] & 8'(DEPTH - 1);
  endfunction

  // Register read decode; clear-on-read handled separately
  function automatic logic [31:0] rd_word(input isb_regs_type q,
                                          input logic [7:0] ad,
                                          input logic [7:0] mb);
    case (ad)
      `ISB_OFF_STATUS:  return {24'h0, q.flags};
      `ISB_OFF_CLR_RD:  return {24'h0, q.flags & `ISB_RD_BITS};
      `ISB_OFF_CLR_WR:  return {24'h0, q.flags & `ISB_WR_BITS};
      `ISB_OFF_ADDR:    return {25'h0, q.own};
      `ISB_OFF_OUT_CFG: return {16'h0, q.out_size, q.out_base};
      `ISB_OFF_IN_CFG:  return {16'h0, q.in_size, q.in_base};
      `ISB_OFF_OUT_CNT: return {24'h0, q.out_cnt};
      `ISB_OFF_IN_CNT:  return {24'h0, q.in_cnt};
      `ISB_OFF_CTRL:    return {27'h0, q.wake_en, q.sleep_req, 2'h0, q.en};
      `ISB_OFF_SLEEP:   return {31'h0, q.asleep};
      `ISB_OFF_IN_DATA: return {16'h0, q.in_ptr, mb};
      default:          return 32'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] ad);
    return ad <= `ISB_OFF_IN_DATA && ad[1:0] == 2'h0;
  endfunction

  // ========================================================
  // Next-state logic
  always_comb begin
    n = r;
    set_f = 8'h00;
    clr_f = 8'h00;
    out_we = 1'b0;
    out_wa = 8'h00;
    out_wd = 8'h00;
    in_we = 1'b0;
    in_wa = 8'h00;
    n.wake = 1'b0;
    // Two flops before any logic looks at a pin
    n.scl_s = {r.scl_s[1:0], scl_i};
    n.sda_s = {r.sda_s[1:0], sda_i};
    scl_rise = r.scl_s[1] & ~r.scl_s[2];
    scl_fall = ~r.scl_s[1] & r.scl_s[2];
    start_ev = r.scl_s[1] & r.scl_s[2] & r.sda_s[2] & ~r.sda_s[1];
    stop_ev  = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[2] & r.sda_s[1];
    matched  = r.en && r.sh[7:1] == r.own;
    wr_exec  = r.aw_got && r.w_got && !r.bvalid;
    rd_take  = s_axi_arvalid && r.arready;

    // Bus protocol engine
    case (r.state)
      ST_ADDR: begin
        if (scl_rise) begin
          n.sh = {r.sh[6:0], r.sda_s[1]};
          n.bits = r.bits + 4'h1;
        end else if (scl_fall && r.bits == `ISB_BITS_BYTE) begin
          n.rw = r.sh[0];
          n.bits = 4'h0;
          n.state = ST_IDLE;
          if (matched && r.asleep) begin
            // Hold the clock until software restores
            n.wake = 1'b1;
            n.scl_oen = 1'b0;
            n.state = ST_WAKE;
          end else if (matched && r.sleep_req && r.wake_en) begin
            n.state = ST_IDLE;
          end else if (matched && r.sh[0]) begin
            set_f[`ISB_F_RD_ACT] = 1'b1;
            n.sda_oen = 1'b0;
            n.state = ST_AACK;
          end else if (matched && r.in_size != 8'h00) begin
            set_f[`ISB_F_WR_ACT] = 1'b1;
            n.sda_oen = 1'b0;
            n.state = ST_AACK;
          end // Unconfigured incoming buffer: NACK
        end
      end
      ST_WAKE: begin
        if (r.asleep == 1'b0) begin
          // Acknowledge and let the clock go again
          n.sda_oen = 1'b0;
          n.scl_oen = 1'b1;
          n.state = ST_AACK;
          set_f[r.rw ? `ISB_F_RD_ACT : `ISB_F_WR_ACT] = 1'b1;
        end
      end
      ST_AACK: begin
        if (scl_fall) begin
          n.sda_oen = 1'b1;
          n.state = r.rw ? ST_TXLD : ST_RX;
          n.scl_oen = ~r.rw;
        end
      end
      ST_TXLD: begin
        // One stretched cycle to fetch the byte
        n.sh = `ISB_IDLE_BYTE;
        if (r.out_size != 8'h00) begin
          if (r.out_cnt == r.out_size) begin
            set_f[`ISB_F_RD_OVR] = 1'b1;
          end else begin
            n.sh = out_mem[buf_idx(r.out_base, r.out_cnt)];
            n.out_cnt = r.out_cnt + 8'h01;
          end
        end
        n.sda_oen = n.sh[7];
        n.scl_oen = 1'b1;
        n.bits = 4'h0;
        n.state = ST_TX;
      end
      ST_TX: begin
        if (scl_fall) begin
          if (r.bits == `ISB_BITS_BYTE - 4'h1) begin
            n.sda_oen = 1'b1;
            n.state = ST_TXACK;
          end else begin
            n.sh = {r.sh[6:0], 1'b0};
            n.sda_oen = r.sh[6];
            n.bits = r.bits + 4'h1;
          end
        end
      end
      ST_TXACK: begin
        if (scl_rise) begin
          n.acked = ~r.sda_s[1];
        end else if (scl_fall) begin
          if (r.acked) begin
            n.scl_oen = 1'b0;
            n.state = ST_TXLD;
          end else begin
            set_f[`ISB_F_RD_DONE] = 1'b1;
            clr_f[`ISB_F_RD_ACT] = 1'b1;
            n.state = ST_IDLE;
          end
        end
      end
      ST_RX: begin
        if (scl_rise) begin
          n.sh = {r.sh[6:0], r.sda_s[1]};
          n.bits = r.bits + 4'h1;
        end else if (scl_fall && r.bits == `ISB_BITS_BYTE) begin
          n.bits = 4'h0;
          n.state = ST_RACK;
          if (r.in_cnt == r.in_size) begin
            set_f[`ISB_F_WR_OVR] = 1'b1;
          end else begin
            in_we = 1'b1;
            in_wa = buf_idx(r.in_base, r.in_cnt);
            n.in_cnt = r.in_cnt + 8'h01;
            n.sda_oen = 1'b0;
          end
        end
      end
      ST_RACK: begin
        if (scl_fall) begin
          n.sda_oen = 1'b1;
          n.state = ST_RX;
        end
      end
      default: begin
        n.bits = 4'h0;
      end
    endcase

    // Start overrides any state except a held wake; stop overrides every state
    if (start_ev && r.state != ST_WAKE) begin
      n.bus_busy = 1'b1;
      n.state = ST_ADDR;
      n.bits = 4'h0;
      n.sda_oen = 1'b1;
      n.scl_oen = 1'b1;
    end else if (stop_ev) begin
      n.bus_busy = 1'b0;
      n.state = ST_IDLE;
      n.sda_oen = 1'b1;
      n.scl_oen = 1'b1;
      if (r.flags[`ISB_F_WR_ACT]) begin
        set_f[`ISB_F_WR_DONE] = 1'b1;
        clr_f[`ISB_F_WR_ACT] = 1'b1;
      end
    end

    // Sleep entry waits for the bus to go quiet
    if (r.sleep_req && r.wake_en && !r.bus_busy && r.state == ST_IDLE) begin
      n.asleep = 1'b1;
    end

    // AXI write channel: address and data in either order
    if (s_axi_awvalid && r.awready) begin
      n.aw_got = 1'b1;
      n.awaddr_h = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      n.w_got = 1'b1;
      n.wdata_h = s_axi_wdata;
      n.wstrb_h = s_axi_wstrb;
    end
    if (wr_exec) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = mapped(r.awaddr_h) ? `ISB_RESP_OK : `ISB_RESP_ERR;
      if (r.wstrb_h[0]) begin
        case (r.awaddr_h)
          `ISB_OFF_ADDR: n.own = r.wdata_h[6:0];
          `ISB_OFF_OUT_CFG: begin
            n.out_base = r.wdata_h[7:0];
            n.out_size = r.wstrb_h[1] ? r.wdata_h[15:8] : r.out_size;
            n.out_cnt = 8'h00;
          end
          `ISB_OFF_IN_CFG: begin
            n.in_base = r.wdata_h[7:0];
            n.in_size = r.wstrb_h[1] ? r.wdata_h[15:8] : r.in_size;
            n.in_cnt = 8'h00;
          end
          `ISB_OFF_CTRL: begin
            n.en = r.wdata_h[`ISB_C_EN];
            n.sleep_req = r.wdata_h[`ISB_C_SLEEP];
            n.wake_en = r.wdata_h[`ISB_C_WAKE_EN];
            if (r.wdata_h[`ISB_C_RW_OUT]) begin
              n.out_cnt = 8'h00;
            end
            if (r.wdata_h[`ISB_C_RW_IN]) begin
              n.in_cnt = 8'h00;
            end
            if (r.wdata_h[`ISB_C_RESTORE]) begin
              n.asleep = 1'b0;
              n.sleep_req = 1'b0;
            end
          end
          `ISB_OFF_OUT_DATA: begin
            out_we = 1'b1;
            out_wa = r.wdata_h[15:8] & 8'(DEPTH - 1);
            out_wd = r.wdata_h[7:0];
          end
          `ISB_OFF_IN_DATA: n.in_ptr = r.wdata_h[7:0] & 8'(DEPTH - 1);
          // Read-only or unmapped: response already chosen above
          default: begin
          end
        endcase
      end
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;

    // AXI read channel; flag clears act on the taken read
    if (rd_take) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rdata = rd_word(r, s_axi_araddr, in_mem[r.in_ptr]);
      n.rresp = mapped(s_axi_araddr) ? `ISB_RESP_OK : `ISB_RESP_ERR;
      if (s_axi_araddr == `ISB_OFF_CLR_RD) begin
        clr_f = clr_f | `ISB_RD_CLR;
      end
      if (s_axi_araddr == `ISB_OFF_CLR_WR) begin
        clr_f = clr_f | `ISB_WR_CLR;
      end
    end else if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end

    // Hardware set wins over a software clear
    n.flags = (r.flags & ~clr_f) | set_f;
  end

  // ========================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.state <= ST_IDLE;
      r.scl_s <= 3'h7;
      r.sda_s <= 3'h7;
      r.scl_oen <= 1'b1;
      r.sda_oen <= 1'b1;
      r.own <= `ISB_RST_ADDR;
      r.flags <= `ISB_RST_BYTE;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Buffers need no reset; they hold payload only
  always_ff @(posedge aclk) begin
    if (out_we) begin
      out_mem[out_wa] <= out_wd;
    end
    if (in_we) begin
      in_mem[in_wa] <= r.sh;
    end
  end

  // ========================================================
  // Outputs
  assign s_axi_awready = r.awready;
  assign s_axi_wready  = r.wready;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign scl_o         = 1'b0; // Open drain only ever pulls low
  assign sda_o         = 1'b0;
  assign scl_oe_n      = r.scl_oen;
  assign sda_oe_n      = r.sda_oen;
  assign wake_pulse    = r.wake;
  assign asleep        = r.asleep;

  // ========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_own_addr;
    wr_exec && r.awaddr_h == `ISB_OFF_ADDR && r.wstrb_h[0]
      |=> r.own == $past(r.wdata_h[6:0]);
  endproperty
  a_own_addr: assert property (p_own_addr)
    else $error("own address not loaded");

  property p_rd_done;
    r.state == ST_TXACK && scl_fall && !r.acked
      |=> r.flags[`ISB_F_RD_DONE] && r.state == ST_IDLE;
  endproperty
  a_rd_done: assert property (p_rd_done)
    else $error("read done not set on master nack");

  property p_rd_busy;
    $rose(r.flags[`ISB_F_RD_DONE]) |-> !r.flags[`ISB_F_RD_ACT];
  endproperty
  a_rd_busy: assert property (p_rd_busy)
    else $error("read active still set at read done");

  property p_wr_done;
    stop_ev && r.flags[`ISB_F_WR_ACT]
      |=> r.flags[`ISB_F_WR_DONE] && !r.flags[`ISB_F_WR_ACT];
  endproperty
  a_wr_done: assert property (p_wr_done)
    else $error("write done not set on stop");

  property p_wr_ovr;
    r.state == ST_RX && scl_fall && r.bits == `ISB_BITS_BYTE
      && r.in_cnt == r.in_size && !start_ev && !stop_ev
      |=> r.sda_oen && r.flags[`ISB_F_WR_OVR];
  endproperty
  a_wr_ovr: assert property (p_wr_ovr)
    else $error("overflowing byte not nacked");

  property p_cnt_sat;
    r.out_cnt <= r.out_size && r.in_cnt <= r.in_size;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat)
    else $error("byte count above buffer size");

  property p_cfg;
    wr_exec && r.awaddr_h == `ISB_OFF_OUT_CFG && r.wstrb_h[0]
      |=> r.out_cnt == 8'h00 ##1 r.out_cnt <= 8'h01;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("outgoing count not zeroed by setup");

  property p_clr_rd;
    rd_take && s_axi_araddr == `ISB_OFF_CLR_RD
      |=> r.rdata[7:0] == ($past(r.flags) & `ISB_RD_BITS);
  endproperty
  a_clr_rd: assert property (p_clr_rd)
    else $error("read flag clear returned wrong value");

  property p_stretch;
    r.state == ST_TXLD |-> !r.scl_oen ##1 r.scl_oen;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock not held during byte fetch");

  property p_wake;
    r.state == ST_ADDR && scl_fall && r.bits == `ISB_BITS_BYTE
      && matched && r.asleep && !start_ev && !stop_ev
      |=> r.wake && !r.scl_oen;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake event on own address");

  c_read:  cover property ($rose(r.flags[`ISB_F_RD_DONE]));
  c_write: cover property ($rose(r.flags[`ISB_F_WR_DONE]));
  c_wake:  cover property (r.state == ST_WAKE ##[1:50] r.state == ST_AACK);

endmodule

// >>> sim/isb_mm.sv
// ==========================================================
// Bus master model for the two-wire link, open-drain drive
module isb_mm (
  // Wire levels seen on the bus
  input  wire logic scl_w,
  input  wire logic sda_w,
  // Drive, 1 releases the line to its pull-up
  output logic      scl_m,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int Q = 16; // Quarter of the 64 ns bus period

  // Idle bus: both lines released, clock stands still
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end

  // One bit slot; the wait honours clock stretching by the slave
  task automatic bit_slot(input logic b, output logic r);
    sda_m = b;
    #Q scl_m = 1'b1;
    wait (scl_w === 1'b1);
    #Q r = sda_w;
    #Q scl_m = 1'b0;
    #Q;
  endtask

  // Start, or repeated start when called in mid-frame
  task automatic start();
    sda_m = 1'b1;
    #Q scl_m = 1'b1;
    wait (scl_w === 1'b1);
    #Q sda_m = 1'b0;
    #(2*Q) scl_m = 1'b0;
    #Q;
  endtask

  // Stop, then the bus is left idle
  task automatic stop();
    sda_m = 1'b0;
    #Q scl_m = 1'b1;
    wait (scl_w === 1'b1);
    #(2*Q) sda_m = 1'b1;
    #(2*Q);
  endtask

  // Byte out MSB first; ack is the ninth bit, low means taken
  task automatic send(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_slot(d[i], ack);
    bit_slot(1'b1, ack);
  endtask

  // Byte in MSB first; last answers with a not-acknowledge
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(last, r);
  endtask
endmodule

// >>> sim/isb_slave_tb.sv
`include "isb_consts.svh"

module isb_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr, rb;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic        scl_m, sda_m, scl_w, sda_w, scl_oe_n, sda_oe_n;
  logic        scl_o, sda_o, wake_pulse, asleep, ack;
  int          err_count, comparisons, wakes;

  // ==========================================================
  // Clock, wired-AND bus with pull-ups, wake counter
  always #2 aclk = ~aclk;
  assign scl_w = scl_m & (scl_oe_n | scl_o);
  assign sda_w = sda_m & (sda_oe_n | sda_o);
  always @(posedge aclk) if (wake_pulse === 1'b1) wakes <= wakes + 1;

  isb_slave u_isb_slave (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .wake_pulse(wake_pulse), .asleep(asleep));
  isb_mm u_isb_mm (.scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m),
    .sda_m(sda_m));

  // ==========================================================
  // Compare, report, end of run
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Register bus master: each channel held until its handshake
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    resp = bresp;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    chk(rd, e);
  endtask

  // ==========================================================
  // Link helpers: address phase, byte out, byte in
  task automatic adr(input logic [7:0] d, input logic e);
    u_isb_mm.start();
    u_isb_mm.send(d, ack);
    chk(ack, e);
  endtask

  task automatic tx(input logic [7:0] d, input logic e);
    u_isb_mm.send(d, ack);
    chk(ack, e);
  endtask

  task automatic rx(input logic last, input logic [7:0] e);
    u_isb_mm.recv(last, rb);
    chk(rb, e);
  endtask

  // Watchdog: the sequence needs well under 200 us
  initial begin
    #200000;
    err_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`ISB_OFF_STATUS, 32'h0);
    rchk(`ISB_OFF_ADDR, 32'h8);
    axr(8'h30);
    chk(resp, `ISB_RESP_ERR);
    axw(8'h31, 32'h0);
    chk(resp, `ISB_RESP_ERR);
    axw(`ISB_OFF_ADDR, 32'h7F);
    axw(`ISB_OFF_CTRL, 32'h1);
    rchk(`ISB_OFF_ADDR, 32'h7F);
    // Nothing configured: writes refused, reads give all ones
    adr(8'hFE, 1'b1);
    u_isb_mm.stop();
    adr(8'hFF, 1'b0);
    rx(1'b0, 8'hFF);
    rx(1'b1, 8'hFF);
    u_isb_mm.stop();
    rchk(`ISB_OFF_CLR_RD, 32'h1);
    // Incoming: two-byte buffer, third byte overflows
    axw(`ISB_OFF_IN_CFG, 32'h0210);
    adr(8'hFC, 1'b1);
    u_isb_mm.stop();
    adr(8'hFE, 1'b0);
    rchk(`ISB_OFF_STATUS, 32'h20);
    tx(8'hA5, 1'b0);
    tx(8'h5A, 1'b0);
    tx(8'h33, 1'b1);
    u_isb_mm.stop();
    rchk(`ISB_OFF_STATUS, 32'h50);
    rchk(`ISB_OFF_IN_CNT, 32'h2);
    axw(`ISB_OFF_IN_DATA, 32'h10);
    axr(`ISB_OFF_IN_DATA);
    chk(rd[7:0], 8'hA5);
    axw(`ISB_OFF_IN_DATA, 32'h11);
    axr(`ISB_OFF_IN_DATA);
    chk(rd[7:0], 8'h5A);
    rchk(`ISB_OFF_CLR_WR, 32'h50);
    rchk(`ISB_OFF_STATUS, 32'h0);
    axw(`ISB_OFF_IN_CFG, 32'h0210);
    rchk(`ISB_OFF_IN_CNT, 32'h0);
    // Outgoing: two-byte buffer, third byte overruns
    axw(`ISB_OFF_OUT_DATA, 32'h20C3);
    axw(`ISB_OFF_OUT_DATA, 32'h213C);
    axw(`ISB_OFF_OUT_CFG, 32'h0220);
    adr(8'hFF, 1'b0);
    rchk(`ISB_OFF_CLR_RD, 32'h2);
    rchk(`ISB_OFF_STATUS, 32'h2);
    rx(1'b0, 8'hC3);
    rx(1'b0, 8'h3C);
    rx(1'b1, 8'hFF);
    u_isb_mm.stop();
    rchk(`ISB_OFF_STATUS, 32'h5);
    rchk(`ISB_OFF_OUT_CNT, 32'h2);
    rchk(`ISB_OFF_CLR_RD, 32'h5);
    axw(`ISB_OFF_CTRL, 32'h3);
    rchk(`ISB_OFF_OUT_CNT, 32'h0);
    adr(8'hFF, 1'b0);
    rx(1'b1, 8'hC3);
    u_isb_mm.stop();
    rchk(`ISB_OFF_OUT_CNT, 32'h1);
    // Sleep requested mid-write: finish it, refuse restart
    adr(8'hFE, 1'b0);
    axw(`ISB_OFF_CTRL, 32'h19);
    tx(8'h11, 1'b0);
    adr(8'hFE, 1'b1);
    u_isb_mm.stop();
    rchk(`ISB_OFF_SLEEP, 32'h1);
    chk(asleep, 1'b1);
    // Own address while asleep: wake, clock held until restore
    fork
      adr(8'hFE, 1'b0);
    join_none
    for (int i = 0; i < 4000 && wakes == 0; i++) @(posedge aclk);
    chk(wakes, 1);
    axw(`ISB_OFF_CTRL, 32'h21);
    wait fork;
    u_isb_mm.stop();
    rchk(`ISB_OFF_SLEEP, 32'h0);
    chk(asleep, 1'b0);
    conclude();
  end
endmodule
